//--- disc_ctrl.sv
// Disc controller end: channel decode, address check, seek, sector locate, record writer.
// Assumes the host end on disc_link_if and drive pins from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module disc_ctrl
(
    input wire logic sys_clk,
    input wire logic nrst,
    disc_link_if.ctrl link,
    input wire logic format_card_fitted,
    input wire logic sector_mark_pin,
    input wire logic heads_positioned_pin,
    input wire logic [5:0] wr_data,
    output logic wr_data_req,
    output logic [3:0] unit_select,
    output logic [7:0] seek_cylinder,
    output logic seek_strobe,
    output logic write_bit,
    output logic write_gate,
    output logic format_mode,
    output logic [3:0] sector_tens,
    output logic [3:0] sector_units,
    output logic addr_fault
);
    import disc_pkg::*;

    // ******************************************
    // Pin synchronisers
    // ******************************************
    logic [2:0] sect_sync_ff;
    logic [2:0] pos_sync_ff;
    logic sect_lvl_ff;
    logic pos_lvl_ff;

    // Change is accepted once stages two and three agree
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sect_sync_ff <= 3'h0;
            pos_sync_ff <= 3'h0;
            sect_lvl_ff <= 1'b0;
            pos_lvl_ff <= 1'b0;
        end
        else
        begin
            sect_sync_ff <= {sect_sync_ff[1:0], sector_mark_pin};
            pos_sync_ff <= {pos_sync_ff[1:0], heads_positioned_pin};
            if (sect_sync_ff[1] == sect_sync_ff[2])
                sect_lvl_ff <= sect_sync_ff[2];
            if (pos_sync_ff[1] == pos_sync_ff[2])
                pos_lvl_ff <= pos_sync_ff[2];
        end
    end

    logic sect_lvl_d_ff;
    logic mark_rise;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            sect_lvl_d_ff <= 1'b0;
        else
            sect_lvl_d_ff <= sect_lvl_ff;
    end
    assign mark_rise = sect_lvl_ff & ~sect_lvl_d_ff;

    // ******************************************
    // Index discrimination
    // ******************************************
    // A mark within the gap after a sector mark is the index; the sector
    // pulse is held back one gap so the index mark does not also count.
    logic [3:0] gap_cnt_ff;
    logic gap_open_ff;
    logic sector_pulse;
    logic index_pulse;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gap_cnt_ff <= 4'h0;
            gap_open_ff <= 1'b0;
        end
        else if (mark_rise && !gap_open_ff)
        begin
            gap_open_ff <= 1'b1;
            gap_cnt_ff <= 4'h0;
        end
        else if (gap_open_ff)
        begin
            if (mark_rise || gap_cnt_ff == 4'(INDEX_GAP_CYC - 1))
                gap_open_ff <= 1'b0;
            gap_cnt_ff <= gap_cnt_ff + 4'h1;
        end
    end
    assign index_pulse = gap_open_ff & mark_rise;
    assign sector_pulse = gap_open_ff & ~mark_rise & (gap_cnt_ff == 4'(INDEX_GAP_CYC - 1));

    sector_counter u_sector_counter
    (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sector_pulse(sector_pulse),
        .index_pulse(index_pulse),
        .tens_digit(sector_tens),
        .units_digit(sector_units)
    );

    // ******************************************
    // Selection and address sequence
    // ******************************************
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_SEEK = 3'b010,
        ST_SEARCH = 3'b011,
        ST_WRITE = 3'b100,
        ST_READ = 3'b101
    } ctrl_state_t;

    ctrl_state_t state_ff;
    logic [3:0] strobe_cnt_ff;
    logic is_write_ff;
    logic [3:0] want_tens_ff;
    logic [3:0] want_units_ff;
    logic [5:0] cyl_char;
    logic [6:0] cyl_num;
    logic [3:0] digit;
    logic select_hit;
    logic func_ok;

    assign digit = link.channel_char[3:0];
    assign func_ok = (link.select_func != FN_OTHER);
    assign select_hit = link.select_valid && func_ok && (link.select_device == DISC_DEVICE);
    assign link.select_ack = select_hit && (state_ff == ST_IDLE);
    assign link.busy = (state_ff != ST_IDLE);
    assign link.retry = select_hit && (state_ff != ST_IDLE);

    logic rec_done;
    // Strobe 1 = unit char, strobes 2..9 carry cylinder, sector and control chars
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ST_IDLE;
            strobe_cnt_ff <= 4'h0;
            is_write_ff <= 1'b0;
            format_mode <= 1'b0;
            unit_select <= 4'h0;
            seek_cylinder <= 8'h00;
            want_tens_ff <= 4'h0;
            want_units_ff <= 4'h0;
            addr_fault <= 1'b0;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                    if (link.select_ack)
                    begin
                        state_ff <= ST_ADDR;
                        strobe_cnt_ff <= 4'h1;
                        is_write_ff <= (link.select_func != FN_READ);
                        format_mode <= (link.select_func == FN_FMT_WRITE) && format_card_fitted;
                        addr_fault <= 1'b0;
                    end
                ST_ADDR:
                    if (link.channel_char_strobe)
                    begin
                        strobe_cnt_ff <= strobe_cnt_ff + 4'h1;
                        if (digit > MAX_DIGIT)
                            addr_fault <= 1'b1;
                        unique case (strobe_cnt_ff)
                            4'h1: unit_select <= digit;
                            4'h2: seek_cylinder[7:4] <= digit;
                            4'h3: seek_cylinder[3:0] <= digit;
                            4'h5: want_tens_ff <= digit;
                            4'h6: want_units_ff <= digit;
                            default: ;
                        endcase
                        if (strobe_cnt_ff == 4'(ADDR_STROBES - 1))
                            state_ff <= (addr_fault || digit > MAX_DIGIT) ? ST_IDLE : ST_SEEK;
                    end
                ST_SEEK:
                    if (pos_lvl_ff)
                        state_ff <= ST_SEARCH;
                ST_SEARCH:
                    if (sector_pulse && sector_tens == want_tens_ff && sector_units == want_units_ff)
                        state_ff <= is_write_ff ? ST_WRITE : ST_READ;
                ST_WRITE, ST_READ:
                    if (rec_done)
                        state_ff <= ST_IDLE;
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    assign seek_strobe = (state_ff == ST_ADDR) && link.channel_char_strobe
        && strobe_cnt_ff == 4'(ADDR_STROBES - 1) && !addr_fault && (digit <= MAX_DIGIT);
    // Cylinder is two decimal digits; the recorded character is its value mod 64
    assign cyl_num = 7'(seek_cylinder[7:4]) * 7'h0a + 7'(seek_cylinder[3:0]);
    assign cyl_char = 6'(cyl_num % 7'(CYL_MODULUS));

    // ******************************************
    // Sector record writer
    // ******************************************
    typedef enum logic [2:0]
    {
        FL_LEADER = 3'b000,
        FL_ALIGN = 3'b001,
        FL_CYL = 3'b010,
        FL_DATA = 3'b011,
        FL_CHECK = 3'b100,
        FL_TRAIL = 3'b101
    } field_t;

    field_t field_ff;
    logic [6:0] char_cnt_ff;
    logic [2:0] bit_cnt_ff;
    logic [5:0] shift_ff;
    logic [5:0] lrc_ff;
    logic [5:0] next_char;
    logic char_end;
    logic active;

    assign active = (state_ff == ST_WRITE) || (state_ff == ST_READ);
    assign char_end = (bit_cnt_ff == 3'(CHAR_BITS - 1));
    assign rec_done = (field_ff == FL_TRAIL) && sector_pulse;
    assign wr_data_req = (state_ff == ST_WRITE) && char_end
        && ((field_ff == FL_CYL) || (field_ff == FL_DATA && char_cnt_ff != 7'(DATA_CHARS - 1)));

    // Character chosen at each boundary; the check char closes even parity
    always_comb
    begin
        next_char = SPACE_CHAR;
        unique case (field_ff)
            FL_LEADER: next_char = (char_cnt_ff == 7'(LEADER_CHARS - 1)) ? ALIGN_CHAR : SPACE_CHAR;
            FL_ALIGN: next_char = cyl_char;
            FL_CYL: next_char = wr_data;
            FL_DATA: next_char = (char_cnt_ff == 7'(DATA_CHARS - 1)) ? (lrc_ff ^ shift_ff) : wr_data;
            FL_CHECK, FL_TRAIL: next_char = ALIGN_CHAR;
            default: next_char = SPACE_CHAR;
        endcase
    end

    // Six bits per character, most significant first
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            field_ff <= FL_LEADER;
            char_cnt_ff <= 7'h00;
            bit_cnt_ff <= 3'h0;
            shift_ff <= SPACE_CHAR;
            lrc_ff <= 6'h00;
        end
        else if (!active)
        begin
            field_ff <= FL_LEADER;
            char_cnt_ff <= 7'h00;
            bit_cnt_ff <= 3'h0;
            shift_ff <= SPACE_CHAR;
            lrc_ff <= 6'h00;
        end
        else if (field_ff == FL_TRAIL)
        begin
            shift_ff <= ALIGN_CHAR;
        end
        else if (!char_end)
        begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
        else
        begin
            bit_cnt_ff <= 3'h0;
            shift_ff <= next_char;
            char_cnt_ff <= char_cnt_ff + 7'h01;
            unique case (field_ff)
                FL_LEADER:
                    if (char_cnt_ff == 7'(LEADER_CHARS - 1))
                    begin
                        field_ff <= FL_ALIGN;
                        char_cnt_ff <= 7'h00;
                    end
                FL_ALIGN:
                begin
                    field_ff <= FL_CYL;
                    lrc_ff <= 6'h00;
                end
                FL_CYL:
                begin
                    field_ff <= FL_DATA;
                    char_cnt_ff <= 7'h00;
                    lrc_ff <= lrc_ff ^ shift_ff;
                end
                FL_DATA:
                begin
                    lrc_ff <= lrc_ff ^ shift_ff;
                    if (char_cnt_ff == 7'(DATA_CHARS - 1))
                        field_ff <= FL_CHECK;
                end
                FL_CHECK: field_ff <= FL_TRAIL;
                default: field_ff <= FL_TRAIL;
            endcase
        end
    end

    assign write_bit = shift_ff[3'(CHAR_BITS - 1) - bit_cnt_ff];
    assign write_gate = (state_ff == ST_WRITE);
    assign link.done = rec_done;
endmodule
`default_nettype wire

//--- disc_pkg.sv
// Package of constants shared by the disc controller ends and the link interface.
// Assumes one 10 MHz clock and an active-low asynchronous reset everywhere.
package disc_pkg;
    // ******************************************
    // Link and channel constants
    // ******************************************
    localparam int unsigned MAX_UNITS = 10;
    localparam int unsigned ADDR_STROBES = 10;
    localparam int unsigned DISC_ADDR_CHARS = 6;
    localparam int unsigned DATA_CHARS = 100;
    localparam int unsigned CHAR_BITS = 6;
    localparam int unsigned LEADER_CHARS = 6;
    localparam int unsigned CYL_MODULUS = 64;
    localparam int unsigned SECTORS_PER_GROUP = 5;
    localparam int unsigned GROUPS_PER_REV = 10;
    // Index mark follows a sector mark within this many cycles
    localparam int unsigned INDEX_GAP_CYC = 8;
    localparam logic [5:0] SPACE_CHAR = 6'h00;
    localparam logic [5:0] ALIGN_CHAR = 6'h3f;
    localparam logic [3:0] MAX_DIGIT = 4'h9;
    localparam logic [3:0] DISC_DEVICE = 4'h0;
    localparam int unsigned BIT5_POS = 5;

    // ******************************************
    // Channel instruction functions
    // ******************************************
    typedef enum logic [1:0]
    {
        FN_READ = 2'b00,
        FN_WRITE = 2'b01,
        FN_FMT_WRITE = 2'b10,
        FN_OTHER = 2'b11
    } func_t;
endpackage

//--- disc_link_if.sv
// Interface joining the host channel end to the disc controller end.
// Assumes both ends share sys_clk; no tristate pins on this link.
`timescale 1ns/10ps
`default_nettype none
interface disc_link_if;
    import disc_pkg::*;
    logic channel_char_strobe;
    logic [7:0] channel_char;
    logic select_valid;
    disc_pkg::func_t select_func;
    logic [3:0] select_device;
    logic select_ack;
    logic busy;
    logic retry;
    logic done;

    modport ctrl
    (
        input channel_char_strobe, channel_char, select_valid, select_func, select_device,
        output select_ack, busy, retry, done
    );
    modport host
    (
        output channel_char_strobe, channel_char, select_valid, select_func, select_device,
        input select_ack, busy, retry, done
    );
endinterface
`default_nettype wire

//--- sector_counter.sv
// Modified-tens sector counter driven by synchronised sector and index pulses.
// Assumes pulses are single-cycle and already in the sys_clk domain.
`timescale 1ns/10ps
`default_nettype none
module sector_counter
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sector_pulse,
    input wire logic index_pulse,
    output logic [3:0] tens_digit,
    output logic [3:0] units_digit
);
    import disc_pkg::*;
    logic [3:0] tens_ff;
    logic [3:0] units_ff;

    // Index mark wins: the revolution restarts at 00
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tens_ff <= 4'h0;
            units_ff <= 4'h0;
        end
        else if (index_pulse)
        begin
            tens_ff <= 4'h0;
            units_ff <= 4'h0;
        end
        else if (sector_pulse)
        begin
            if (tens_ff == 4'(SECTORS_PER_GROUP - 1))
            begin
                tens_ff <= 4'h0;
                units_ff <= (units_ff == MAX_DIGIT) ? 4'h0 : units_ff + 4'h1;
            end
            else
            begin
                tens_ff <= tens_ff + 4'h1;
            end
        end
    end

    assign tens_digit = tens_ff;
    assign units_digit = units_ff;
endmodule
`default_nettype wire

//--- disc_host.sv
// Host channel end: routes disc instructions, checks address characters, strobes them out.
// Assumes the controller end on disc_link_if; memory fetch is done by the user side.
`timescale 1ns/10ps
`default_nettype none
module disc_host
(
    input wire logic sys_clk,
    input wire logic nrst,
    disc_link_if.host link,
    input wire logic instr_valid,
    input wire logic [3:0] first_length_digit,
    input wire logic [3:0] second_length_digit,
    input wire disc_pkg::func_t instr_func,
    input wire logic large_model,
    input wire logic [7:0] addr_char,
    output logic instr_taken,
    output logic instr_restore,
    output logic data_fault,
    output logic [6:0] data_count
);
    import disc_pkg::*;
    typedef enum logic [1:0]
    {
        H_IDLE = 2'b00,
        H_SEL = 2'b01,
        H_SEND = 2'b10
    } host_state_t;

    host_state_t state_ff;
    logic [3:0] cnt_ff;
    logic routed;
    logic char_bad;

    // disc when first digit zero and second zero or two
    assign routed = instr_valid && first_length_digit == 4'h0
        && (second_length_digit == 4'h0 || second_length_digit == 4'h2);
    assign char_bad = (addr_char[3:0] > MAX_DIGIT) || (!large_model && !addr_char[BIT5_POS]);
    assign link.select_valid = (state_ff == H_SEL);
    assign link.select_func = instr_func;
    assign link.select_device = DISC_DEVICE;
    assign link.channel_char_strobe = (state_ff == H_SEND);
    // A faulted character goes out with an illegal digit, so the controller drops the address
    assign link.channel_char = (char_bad && cnt_ff <= 4'(DISC_ADDR_CHARS))
        ? {addr_char[7:4], 4'hf} : addr_char;
    assign instr_taken = (state_ff == H_SEL) && link.select_ack;
    assign instr_restore = (state_ff == H_SEL) && !link.select_ack;
    assign data_count = 7'(DATA_CHARS);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= H_IDLE;
            cnt_ff <= 4'h0;
            data_fault <= 1'b0;
        end
        else
        begin
            unique case (state_ff)
                H_IDLE:
                    if (routed)
                    begin
                        state_ff <= H_SEL;
                        data_fault <= 1'b0;
                    end
                H_SEL:
                begin
                    state_ff <= link.select_ack ? H_SEND : H_IDLE;
                    cnt_ff <= 4'h1;
                end
                H_SEND:
                begin
                    if (char_bad && cnt_ff <= 4'(DISC_ADDR_CHARS))
                        data_fault <= 1'b1;
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == 4'(ADDR_STROBES - 1))
                        state_ff <= H_IDLE;
                end
                default:
                    state_ff <= H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- disc_link_asserts.sv
// Concurrent checks on the host-to-controller link signals.
// Assumes one sys_clk domain, nrst active low, instantiated beside the link.
`timescale 1ns/10ps
`default_nettype none
module disc_link_asserts
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic channel_char_strobe,
    input wire logic select_valid,
    input wire disc_pkg::func_t select_func,
    input wire logic [3:0] select_device,
    input wire logic select_ack,
    input wire logic busy,
    input wire logic retry,
    input wire logic done
);
    import disc_pkg::*;
    // ******************************************
    // Link protocol checks
    // ******************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // Length of the current strobe train; a tenth strobe would mean a stray character
    logic [3:0] run_ff;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            run_ff <= 4'h0;
        else
            run_ff <= channel_char_strobe ? run_ff + 4'h1 : 4'h0;
    end

    sequence s_select;
        select_valid && select_ack;
    endsequence
    sequence s_train_start;
        channel_char_strobe && !$past(channel_char_strobe);
    endsequence

    a_ack_qualified: assert property
        (select_ack |-> select_valid && select_func != FN_OTHER && select_device == DISC_DEVICE)
        else $error("ack without a disc select");
    a_ack_single: assert property
        (s_select |=> !select_ack)
        else $error("ack longer than one cycle");
    a_train_order: assert property
        (s_train_start |-> $past(select_ack))
        else $error("strobe train without ack");
    a_train_bound: assert property
        (channel_char_strobe |-> run_ff < 4'h9)
        else $error("strobe train too long");
    a_busy_refuses: assert property
        (select_valid && select_func != FN_OTHER && busy |-> retry && !select_ack)
        else $error("busy controller not refusing");
    a_retry_cause: assert property
        (retry |-> select_valid && !select_ack)
        else $error("retry without select");
    a_busy_after_ack: assert property
        (s_select |=> busy)
        else $error("controller idle after ack");
    a_done_single: assert property
        (done |=> !done)
        else $error("done longer than one cycle");
    a_done_quiet: assert property
        (done |-> !channel_char_strobe && !select_ack)
        else $error("done during selection");
endmodule
`default_nettype wire

//--- disc_sector_locate_and_format_test.sv
// Testbench joining host and controller ends over the link, drive pins modelled here.
// Assumes the package constants and one 10 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module disc_sector_locate_and_format_test;
    import disc_pkg::*;
    // ******************************************
    // Stimulus, monitors and checks
    // ******************************************
    logic sys_clk = 1'b0, nrst = 1'b0, instr_valid = 1'b0, large_model = 1'b0;
    logic [3:0] first_length_digit = 4'h0, second_length_digit = 4'h0;
    func_t instr_func = FN_READ;
    logic [7:0] addr_char = 8'h20;
    logic format_card_fitted = 1'b0, sector_mark_pin = 1'b0, heads_positioned_pin = 1'b0;
    logic [5:0] wr_data = 6'h00;
    logic instr_taken, instr_restore, data_fault, wr_data_req, seek_strobe, write_bit;
    logic write_gate, format_mode, addr_fault, seek_fmt;
    logic [6:0] data_count;
    logic [3:0] unit_select, sector_tens, sector_units, seek_unit;
    logic [7:0] seek_cylinder, seek_cyl;
    logic [5:0] dq[$];
    logic bq[$];
    integer seed = 55;
    int fails = 0, compares = 0, seeks = 0;
    bit done_seen = 0;

    disc_link_if link_i();
    disc_host disc_host_i(.sys_clk(sys_clk), .nrst(nrst), .link(link_i.host),
        .instr_valid(instr_valid), .first_length_digit(first_length_digit),
        .second_length_digit(second_length_digit), .instr_func(instr_func),
        .large_model(large_model), .addr_char(addr_char), .instr_taken(instr_taken),
        .instr_restore(instr_restore), .data_fault(data_fault), .data_count(data_count));
    disc_ctrl disc_ctrl_i(.sys_clk(sys_clk), .nrst(nrst), .link(link_i.ctrl),
        .format_card_fitted(format_card_fitted), .sector_mark_pin(sector_mark_pin),
        .heads_positioned_pin(heads_positioned_pin), .wr_data(wr_data),
        .wr_data_req(wr_data_req), .unit_select(unit_select), .seek_cylinder(seek_cylinder),
        .seek_strobe(seek_strobe), .write_bit(write_bit), .write_gate(write_gate),
        .format_mode(format_mode), .sector_tens(sector_tens), .sector_units(sector_units),
        .addr_fault(addr_fault));
    disc_link_asserts disc_link_asserts_i(.sys_clk(sys_clk), .nrst(nrst),
        .channel_char_strobe(link_i.channel_char_strobe), .select_valid(link_i.select_valid),
        .select_func(link_i.select_func), .select_device(link_i.select_device),
        .select_ack(link_i.select_ack), .busy(link_i.busy), .retry(link_i.retry),
        .done(link_i.done));

    // Clock, and write data that changes every cycle so a stale character shows
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) wr_data <= 6'($random(seed));

    // Sample controller outputs mid-cycle, where they have settled
    always @(negedge sys_clk)
    begin
        if (wr_data_req) dq.push_back(wr_data);
        if (write_gate) bq.push_back(write_bit);
        if (link_i.done) done_seen = 1;
        if (seek_strobe)
        begin
            seeks++;
            seek_unit = unit_select;
            seek_cyl = seek_cylinder;
            seek_fmt = format_mode;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Mark three cycles high, then a quiet gap; an index is two marks five cycles apart
    task automatic mark(input int gap);
        sector_mark_pin <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sector_mark_pin <= 1'b0;
        repeat (gap) @(posedge sys_clk);
    endtask

    // Modified-tens number of the k-th sector after index, as {tens, units}
    function automatic logic [7:0] exp_sector(input int k);
        return {4'(k % 5), 4'(k / 5)};
    endfunction

    // Six recorded bits from position p, first bit most significant
    function automatic logic [5:0] get6(input int p);
        logic [5:0] v;
        for (int i = 0; i < 6; i++) v[5 - i] = bq[p + i];
        return v;
    endfunction

    // Hold one instruction until the host takes or restores it, or a limit passes
    task automatic issue(input func_t f, input logic [3:0] fld, input logic [3:0] sld,
                         input logic [7:0] ch, input logic lg, output logic [1:0] ans);
        instr_func <= f;
        first_length_digit <= fld;
        second_length_digit <= sld;
        addr_char <= ch;
        large_model <= lg;
        instr_valid <= 1'b1;
        ans = 2'b00;
        for (int i = 0; i < 8 && ans == 2'b00; i++)
        begin
            @(negedge sys_clk);
            ans = {instr_taken, instr_restore};
            @(posedge sys_clk);
        end
        instr_valid <= 1'b0;
    endtask

    // Full write to sector dd of cylinder dd, then the recorded bits are taken apart
    task automatic write_op(input func_t f, input logic card, input logic lg,
                            input logic [3:0] sld);
        logic [1:0] ans;
        logic [3:0] d;
        logic [7:0] ch;
        logic [5:0] lrc;
        logic ones;
        d = 4'(($random(seed) & 32'hff) % 5);
        ch = {1'($random(seed)), 1'b0, (lg ? 1'($random(seed)) : 1'b1), 1'b0, d};
        format_card_fitted <= card;
        heads_positioned_pin <= 1'b0;
        seeks = 0;
        issue(f, 4'h0, sld, ch, lg, ans);
        check("taken", ans, 2'b10);
        for (int i = 0; i < 40 && seeks == 0; i++) @(posedge sys_clk);
        check("seeks", 16'(seeks), 1);
        check("unit", seek_unit, d);
        check("cyl", seek_cyl, {d, d});
        check("fmt", seek_fmt, f == FN_FMT_WRITE && card);
        check("fault", {data_fault, addr_fault}, 0);
        repeat (10) @(posedge sys_clk);
        check("gate", write_gate, 0);
        dq.delete();
        bq.delete();
        done_seen = 0;
        heads_positioned_pin <= 1'b1;
        mark(2);
        mark(20);
        for (int i = 0; i < 40 && !done_seen; i++) mark(700);
        check("done", done_seen, 1);
        check("nchar", 16'(dq.size()), 100);
        for (int i = 0; i < 6; i++) check("lead", get6(6 * i), SPACE_CHAR);
        check("align", get6(36), ALIGN_CHAR);
        lrc = 6'((11 * d) % 64);
        check("cylch", get6(42), 6'((11 * d) % 64));
        for (int i = 0; i < 100; i++)
        begin
            check("data", get6(48 + 6 * i), dq[i]);
            lrc ^= dq[i];
        end
        check("lrc", get6(648), lrc);
        ones = bq.size() > 654;
        for (int i = 654; i < bq.size(); i++) ones &= bq[i];
        check("trail", ones, 1);
    endtask

    initial
    begin
        logic [1:0] ans;
        logic [7:0] rt[4] = '{8'h10, 8'h01, 8'h03, 8'h92};
        logic [7:0] ft[3] = '{8'h03, 8'h2a, 8'hac};
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        // Counter walks the modified-tens order and clears on index
        mark(2);
        mark(20);
        for (int k = 1; k < 50; k++)
        begin
            mark(25);
            check("sect", {sector_tens, sector_units}, exp_sector(k));
        end
        check("last", {sector_tens, sector_units}, 8'h49);
        mark(2);
        mark(20);
        check("index", {sector_tens, sector_units}, 8'h00);
        // Non-disc length digits never reach the controller
        for (int i = 0; i < 4; i++)
        begin
            issue(FN_READ, rt[i][7:4], rt[i][3:0], 8'h21, 1'b0, ans);
            check("route", ans, 2'b00);
        end
        issue(FN_OTHER, 4'h0, 4'h0, 8'h21, 1'b0, ans);
        check("other", ans, 2'b01);
        // Bad address characters fault with no seek
        for (int i = 0; i < 3; i++)
        begin
            seeks = 0;
            issue(FN_READ, 4'h0, 4'h0, ft[i], 1'(i == 2), ans);
            repeat (30) @(posedge sys_clk);
            check("dfault", data_fault, 1);
            check("noseek", 16'(seeks), 0);
        end
        nrst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        write_op(FN_WRITE, 1'b0, 1'b0, 4'h0);
        write_op(FN_FMT_WRITE, 1'b0, 1'b1, 4'h2);
        write_op(FN_FMT_WRITE, 1'b1, 1'b0, 4'h0);
        // A seeking controller turns the next instruction back
        heads_positioned_pin <= 1'b0;
        issue(FN_READ, 4'h0, 4'h2, 8'ha1, 1'b0, ans);
        repeat (20) @(posedge sys_clk);
        issue(FN_WRITE, 4'h0, 4'h0, 8'h21, 1'b0, ans);
        check("retry", ans, 2'b01);
        check("count", data_count, 7'h64);
        end_sim();
    end

    // Cut a hang short well past the longest expected run
    initial
    begin
        #9800000;
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
